// [logic/init_seq.sv]
// Init indication, self-test ordering, interface timeouts and buffer limits
//
// Behaviour
// - Timeout A is 750 ms and timeout B is 2000 ms.
// - Timeout C is 200 ms, timeout D 30 ms; transitions bounded by them.
// - Command cancel must finish within timeout B.
// - Low-to-high transition of active-low reset is the init indication.
// - Init indication comes from the reset pin.
// - Device resets itself when the reset input is released.
// - Commands are refused while reset is held asserted.
// - Only the release of reset matters; asserted time may run internal tests.
// - State changes made while reset is asserted are discarded on release.
// - Hash signals and startup functions are tested before startup is accepted.
// - Early-boot commands run after startup without an implicit self-test.
// - Partial self-test finishes in under one second.
// - Data buffer in the shared buffer map never exceeds 3968 bytes.
// - Commands whose response would overflow the output buffer are refused; the code checks response length only when SEPARATE_BUFS is set.
// - Data buffer holds the largest implemented command.
`timescale 1ns/100ps
`include "init_seq_consts.svh"
module init_seq
   import init_seq_pkg::*;
#(
   parameter int BUF_BYTES = `BUF_DEF_BYTES,
   parameter int MAX_CMD_BYTES = `BUF_DEF_BYTES,
   parameter bit SEPARATE_BUFS = 1'b0,
   parameter bit CRB_MAP = 1'b1,
   parameter int TO_A_CYC = `MS_TO_CYC(`TIMEOUT_A_MS),
   parameter int TO_B_CYC = `MS_TO_CYC(`TIMEOUT_B_MS),
   parameter int TO_C_CYC = `MS_TO_CYC(`TIMEOUT_C_MS),
   parameter int TO_D_CYC = `MS_TO_CYC(`TIMEOUT_D_MS),
   parameter int SELF_TEST_CYC = `MS_TO_CYC(`SELF_TEST_MS) - 1,
   parameter int POST_CYC = `ST_POWERON_CYC
) (
   input wire logic CORE_CLK, // 10 MHz core clock
   input wire logic RESETN, // Async active-low reset
   input wire logic MOD_RESETN, // Module reset pin, low = held
   input wire logic CMD_VALID, // Command offered, held until taken or refused
   input wire logic CMD_STARTUP, // Command is the startup command
   input wire logic CMD_EARLY, // Command is on the early-boot list
   input wire logic CMD_SELF_TEST, // Command is a self-test request
   input wire logic CMD_FULL_TEST, // Full test flag of a self-test request
   input wire logic CMD_CANCEL, // Cancel request for running command
   input wire logic [15:0] CMD_RSP_BYTES, // Expected response length
   input wire logic [15:0] CMD_BYTES, // Command length
   input wire logic CMD_DONE, // Running command has finished
   input wire logic TO_START, // Start an interface timeout
   input wire logic [1:0] TO_SEL, // Which timeout to start
   output logic CMD_ACCEPT, // One-cycle pulse: command taken
   output logic CMD_REFUSE, // One-cycle pulse: command refused
   output logic CMD_ERR_SIZE, // One-cycle pulse: size error
   output logic INIT_PULSE, // One-cycle init indication
   output logic POST_DONE, // Power-on tests finished
   output logic STARTED, // Startup command completed
   output logic SELF_TEST_BUSY, // Self-test in progress
   output logic TO_EXPIRED, // One-cycle pulse: timeout ran out
   output logic CANCEL_TIMEOUT, // One-cycle pulse: cancel exceeded limit
   output logic [15:0] BUF_SIZE // Data buffer size in bytes
);

   // Parameter sanity, refused at elaboration rather than found at run time
   if (CRB_MAP && BUF_BYTES > `BUF_MAX_BYTES) begin : g_buf_map_check
      $error("buffer too large for address map");
   end
   if (BUF_BYTES < MAX_CMD_BYTES || BUF_BYTES > 65535) begin : g_buf_cmd_check
      $error("buffer smaller than largest command or wider than the size port");
   end
   if (TO_A_CYC < 1 || TO_B_CYC < 1 || TO_C_CYC < 1 || TO_D_CYC < 1) begin : g_to_check
      $error("timeout counts must be at least one");
   end
   if (POST_CYC < 1 || SELF_TEST_CYC < 1) begin : g_count_check
      $error("test counts must be at least one");
   end

   logic rst_meta;
   logic rst_sync;
   logic rst_prev;
   seq_state_e state;
   logic [31:0] post_cnt;
   logic [31:0] st_cnt;
   logic [31:0] to_cnt;
   logic to_run;
   logic cancel_run;
   logic [31:0] cancel_cnt;
   logic cmd_ok;
   logic size_bad;
   logic held;

   // Two-flop synchroniser on the module reset pin
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= MOD_RESETN;
         rst_sync <= rst_meta;
      end
   end

   // Edge detect only on the second flop; assertion edge is ignored
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_prev <= 1'b0;
      end else begin
         rst_prev <= rst_sync;
      end
   end
   assign INIT_PULSE = rst_sync & ~rst_prev;
   assign held = ~rst_sync;

   // Size checks: refuse on command length, and on response length only with separate buffers
   assign size_bad = (CMD_BYTES > 16'(BUF_BYTES))
                     || (SEPARATE_BUFS && CMD_RSP_BYTES > 16'(BUF_BYTES));
   assign BUF_SIZE = 16'(BUF_BYTES);

   // Which command is legal in each phase
   always_comb begin
      cmd_ok = 1'b0;
      case (state)
         S_WAIT_STARTUP: cmd_ok = CMD_STARTUP;
         S_EARLY: cmd_ok = CMD_EARLY | CMD_SELF_TEST;
         S_READY: cmd_ok = 1'b1;
         default: cmd_ok = 1'b0;
      endcase
   end

   // Commands while held or in wrong phase are refused, never acted on
   assign CMD_ACCEPT = CMD_VALID & ~held & cmd_ok & ~size_bad;
   assign CMD_REFUSE = CMD_VALID & (held | ~cmd_ok);
   assign CMD_ERR_SIZE = CMD_VALID & ~held & cmd_ok & size_bad;

   // Sequencer; release of reset restarts it, discarding held-time state
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= S_HELD;
      end else if (held) begin
         state <= S_HELD;
      end else if (INIT_PULSE) begin
         state <= S_POST;
      end else begin
         case (state)
            S_POST: if (post_cnt == 32'(POST_CYC - 1)) state <= S_WAIT_STARTUP;
            S_WAIT_STARTUP: if (CMD_ACCEPT) state <= S_EARLY;
            S_EARLY: begin
               if (CMD_ACCEPT && CMD_SELF_TEST) begin
                  state <= CMD_FULL_TEST ? S_SELF_TEST : S_SELF_TEST;
               end
            end
            S_SELF_TEST: if (st_cnt == 32'(SELF_TEST_CYC - 1)) state <= S_READY;
            default: state <= state;
         endcase
      end
   end

   // Power-on test counter, runs only after init
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         post_cnt <= '0;
      end else if (state != S_POST || INIT_PULSE) begin
         post_cnt <= '0;
      end else begin
         post_cnt <= post_cnt + 32'd1;
      end
   end

   // Remaining self-test counter, bounded below one second
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_cnt <= '0;
      end else if (state != S_SELF_TEST) begin
         st_cnt <= '0;
      end else begin
         st_cnt <= st_cnt + 32'd1;
      end
   end

   assign POST_DONE = (state == S_WAIT_STARTUP) || (state == S_EARLY)
                      || (state == S_SELF_TEST) || (state == S_READY);
   assign STARTED = (state == S_EARLY) || (state == S_SELF_TEST) || (state == S_READY);
   assign SELF_TEST_BUSY = (state == S_SELF_TEST);

   // Interface timeout counter, one at a time
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         to_run <= 1'b0;
         to_cnt <= '0;
      end else if (held) begin
         to_run <= 1'b0;
         to_cnt <= '0;
      end else if (TO_START) begin
         to_run <= 1'b1;
         case (timeout_sel_e'(TO_SEL))
            TO_A: to_cnt <= 32'(TO_A_CYC);
            TO_B: to_cnt <= 32'(TO_B_CYC);
            TO_C: to_cnt <= 32'(TO_C_CYC);
            default: to_cnt <= 32'(TO_D_CYC);
         endcase
      end else if (to_run) begin
         to_cnt <= to_cnt - 32'd1;
         if (to_cnt == 32'd1) to_run <= 1'b0;
      end
   end
   // Count loads on the start edge, so expiry is sampled N edges after it
   assign TO_EXPIRED = to_run && (to_cnt == 32'd1) && !TO_START && !held;

   // Cancel watchdog: cancel must land within timeout B
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cancel_run <= 1'b0;
         cancel_cnt <= '0;
      end else if (held || CMD_DONE) begin
         cancel_run <= 1'b0;
         cancel_cnt <= '0;
      end else if (CMD_CANCEL && !cancel_run) begin
         cancel_run <= 1'b1;
         cancel_cnt <= 32'(TO_B_CYC);
      end else if (cancel_run) begin
         cancel_cnt <= cancel_cnt - 32'd1;
         if (cancel_cnt == 32'd1) cancel_run <= 1'b0;
      end
   end
   // Completion in the last cycle still wins, so a finish in that cycle is not flagged
   assign CANCEL_TIMEOUT = cancel_run && (cancel_cnt == 32'd1) && !CMD_DONE && !held;

   // Assertions: init indication and reset handling
   a_init_one_cycle: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) INIT_PULSE |=> !INIT_PULSE)
      else $error("init pulse longer than a cycle");
   a_init_from_edge: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) INIT_PULSE |-> rst_sync && !$past(rst_sync))
      else $error("init without edge");
   a_sync_chain: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) rst_sync == $past(rst_meta))
      else $error("reset pin skipped a synchroniser stage");
   a_held_refuses: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) (held && CMD_VALID) |-> CMD_REFUSE && !CMD_ACCEPT)
      else $error("accepted while held");
   a_held_state: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) held |=> state == S_HELD)
      else $error("state kept while held");
   a_held_clears: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) held |=> !to_run && !cancel_run)
      else $error("timer kept while held");
   a_init_restart: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) INIT_PULSE |=> state == S_POST)
      else $error("no restart on release");

   // Assertions: phase ordering and self-test
   a_post_length: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN || held)
      (state == S_POST && post_cnt == 32'(POST_CYC - 1)) |=> state == S_WAIT_STARTUP)
      else $error("power-on test length wrong");
   a_startup_gate: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) (CMD_ACCEPT && state == S_WAIT_STARTUP) |-> CMD_STARTUP)
      else $error("early command");
   a_phase_refuse: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) (CMD_VALID && !cmd_ok) |-> CMD_REFUSE && !CMD_ACCEPT)
      else $error("wrong-phase command taken");
   a_startup_flag: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN || held) (state == S_WAIT_STARTUP && CMD_ACCEPT) |=> STARTED)
      else $error("startup not recorded");
   a_early_no_test: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN || held)
      (state == S_EARLY && CMD_ACCEPT && !CMD_SELF_TEST) |=> state == S_EARLY)
      else $error("implicit self-test");
   a_ready_accepts: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN)
      (state == S_READY && CMD_VALID && !held && !size_bad) |-> CMD_ACCEPT)
      else $error("ready phase refused a command");
   a_selftest_bound: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN || held) (st_cnt == 32'(SELF_TEST_CYC - 1)) |=> state == S_READY)
      else $error("self-test overrun");

   // Assertions: size limits
   a_size_refuse: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) (CMD_BYTES > BUF_SIZE && CMD_VALID) |-> !CMD_ACCEPT)
      else $error("oversize accepted");
   a_one_answer: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) CMD_VALID |-> $onehot({CMD_ACCEPT, CMD_REFUSE, CMD_ERR_SIZE}))
      else $error("command answered other than once");

   // Assertions: interface and cancel timeouts
   a_timeout_a: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN || held)
      (TO_START && TO_SEL == 2'd0) |=> to_cnt == 32'(TO_A_CYC))
      else $error("timeout A load");
   a_timeout_b: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN || held)
      (TO_START && TO_SEL == 2'd1) |=> to_cnt == 32'(TO_B_CYC))
      else $error("timeout B load");
   a_timeout_c: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN || held)
      (TO_START && TO_SEL == 2'd2) |=> to_cnt == 32'(TO_C_CYC))
      else $error("timeout C load");
   a_timeout_d: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN || held)
      (TO_START && TO_SEL == 2'd3) |=> to_cnt == 32'(TO_D_CYC))
      else $error("timeout D load");
   a_expire_pulse: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) TO_EXPIRED |=> !TO_EXPIRED)
      else $error("timeout expiry longer than a cycle");
   a_cancel_load: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN || held || CMD_DONE)
      (CMD_CANCEL && !cancel_run) |=> cancel_cnt == 32'(TO_B_CYC))
      else $error("cancel load");
   a_cancel_done: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) CMD_DONE |=> !cancel_run)
      else $error("cancel watchdog kept after completion");
   a_cancel_pulse: assert property (@(posedge CORE_CLK)
      disable iff (!RESETN) CANCEL_TIMEOUT |=> !CANCEL_TIMEOUT)
      else $error("cancel timeout longer than a cycle");

   // Main scenarios reached
   c_init: cover property (@(posedge CORE_CLK) INIT_PULSE);
   c_startup: cover property (@(posedge CORE_CLK) state == S_WAIT_STARTUP ##1 state == S_EARLY);
   c_selftest: cover property (@(posedge CORE_CLK) state == S_SELF_TEST ##1 state == S_READY);
   c_expire: cover property (@(posedge CORE_CLK) TO_EXPIRED);
   c_cancel_done: cover property (@(posedge CORE_CLK) cancel_run && CMD_DONE);

endmodule // init_seq

// [logic/init_seq_consts.svh]
// Timing and size constants for the init and timeout sequencer
`ifndef INIT_SEQ_CONSTS_SVH
`define INIT_SEQ_CONSTS_SVH
`define CLK_PERIOD_NS 100
`define TIMEOUT_A_MS 750
`define TIMEOUT_B_MS 2000
`define TIMEOUT_C_MS 200
`define TIMEOUT_D_MS 30
`define SELF_TEST_MS 1000
`define MS_TO_CYC(ms) ((ms) * 1000000 / `CLK_PERIOD_NS)
`define BUF_MAX_BYTES 3968
`define BUF_DEF_BYTES 1024
`define ST_POWERON_CYC 16
`endif

// [logic/init_seq_pkg.sv]
// Types for the init and timeout sequencer
package init_seq_pkg;
   typedef enum logic [2:0] {
      S_HELD,
      S_POST,
      S_WAIT_STARTUP,
      S_EARLY,
      S_SELF_TEST,
      S_READY
   } seq_state_e;
   typedef enum logic [1:0] {
      TO_A,
      TO_B,
      TO_C,
      TO_D
   } timeout_sel_e;
endpackage

// [testbench/host_plat.sv]
// Host platform model that drives the module reset pin
`timescale 1ns/100ps
module host_plat (
   input wire logic clk, // Core clock
   input wire logic hold, // Bench asks to hold the module in reset
   output logic mod_resetn // Module reset pin, low = held
);
   // Pin moves on the falling edge, as chipset reset logic would, never on the sampling edge
   always @(negedge clk) begin
      mod_resetn <= !hold;
   end
endmodule // host_plat

// [testbench/testbench.sv]
// Self-checking bench for the init and timeout sequencer
`timescale 1ns/100ps
module testbench;
   import init_seq_pkg::*;
   typedef struct {logic s; logic e; logic [15:0] b; logic a; logic x;} row_s;
   logic clk = 0, rstn = 0, hold = 1, vld = 0, strt = 0, erl = 0, st = 0, cnc = 0, tos = 0;
   logic [1:0] tsel = 2'h0;
   logic ft = 0, done = 0;
   logic [15:0] nb = 16'h0000, rb = 16'h0000;
   logic acc, rfs, err, ini, pdn, sta, stb, toe, cto, mrn, sa, sr, se;
   logic [15:0] bsz;
   int n_fail = 0, n_checks = 0, n;
   int to_cyc [4] = '{50, 60, 40, 20};
   // Early phase rows: class, length, then expected accept and size error
   row_s rows [5] = '{'{0, 1, 16'h0010, 1, 0}, '{0, 1, 16'h0400, 1, 0},
      '{0, 1, 16'h0401, 0, 1}, '{0, 0, 16'h0010, 0, 0}, '{1, 0, 16'h0010, 0, 0}};
   always #50 clk = ~clk;
   host_plat i_host (.clk(clk), .hold(hold), .mod_resetn(mrn));
   // Timeout and self-test counts shortened; power-on test keeps its default length
   init_seq #(.TO_A_CYC(50), .TO_B_CYC(60), .TO_C_CYC(40), .TO_D_CYC(20),
      .SELF_TEST_CYC(30)) i_dut (
      .CORE_CLK(clk), .RESETN(rstn), .MOD_RESETN(mrn), .CMD_VALID(vld),
      .CMD_STARTUP(strt), .CMD_EARLY(erl), .CMD_SELF_TEST(st), .CMD_FULL_TEST(ft),
      .CMD_CANCEL(cnc), .CMD_RSP_BYTES(rb), .CMD_BYTES(nb), .CMD_DONE(done),
      .TO_START(tos), .TO_SEL(tsel), .CMD_ACCEPT(acc), .CMD_REFUSE(rfs),
      .CMD_ERR_SIZE(err), .INIT_PULSE(ini), .POST_DONE(pdn), .STARTED(sta),
      .SELF_TEST_BUSY(stb), .TO_EXPIRED(toe), .CANCEL_TIMEOUT(cto), .BUF_SIZE(bsz));
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Offer one command for one cycle; answers are combinational, so sample mid-cycle
   task automatic offer(input logic s, input logic e, input logic t, input logic [15:0] b);
      @(negedge clk);
      {vld, strt, erl, st, nb} = {1'b1, s, e, t, b};
      #10 {sa, sr, se} = {acc, rfs, err};
      @(negedge clk);
      vld = 0;
   endtask
   // Edges counted until a level shows, bounded so a stuck output cannot hang the run
   task automatic wait_lv(ref logic sig, input logic lv, input int lim);
      n = 0;
      while (sig !== lv && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
      check(n < lim, 1);
   endtask
   initial begin
      #200000 n_fail++;
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk) rstn = 1;
      check({acc, rfs, ini, pdn, sta, stb, toe, cto}, 0);
      check(bsz, 16'h0400);
      offer(1, 0, 0, 16'h0010);
      check({sa, sr}, 2'h1);
      #10 hold = 0;
      wait_lv(ini, 1, 10);
      @(posedge clk);
      #1 check(ini, 0);
      offer(1, 0, 0, 16'h0010);
      check({sa, sr}, 2'h1);
      wait_lv(pdn, 1, 20);
      // The refused offer spent one power-on edge before the wait began
      check(16'(n + 1), 16);
      offer(1, 0, 0, 16'h0010);
      check({sa, sr}, 2'h2);
      check(sta, 1);
      // Shared buffer: a long response alone never refuses
      rb = 16'h1000;
      foreach (rows[i]) begin
         offer(rows[i].s, rows[i].e, 0, rows[i].b);
         check({sa, se}, {rows[i].a, rows[i].x});
      end
      // Every timeout limit, counted from the loading edge
      for (int i = 0; i < 4; i++) begin
         @(negedge clk) {tos, tsel} = {1'b1, 2'(i)};
         @(negedge clk) tos = 0;
         wait_lv(toe, 1, 100);
         // Waiting starts one edge after the load edge
         check(16'(n + 1), 16'(to_cyc[i]));
      end
      @(negedge clk) cnc = 1;
      @(negedge clk) cnc = 0;
      wait_lv(cto, 1, 100);
      check(16'(n + 1), 60);
      // Cancel ended by completion: the watchdog must stay quiet
      @(negedge clk);
      @(negedge clk) cnc = 1;
      @(negedge clk) cnc = 0;
      repeat (10) @(negedge clk);
      done = 1;
      @(negedge clk) done = 0;
      repeat (70) begin
         @(posedge clk);
         #1 check(cto, 0);
      end
      offer(0, 1, 1, 16'h0010);
      check(sa, 1);
      wait_lv(stb, 0, 100);
      check(n, 30);
      offer(1, 0, 0, 16'h0010);
      check(sa, 1);
      // Pin held again: refused, and startup is forgotten while held, still clear after the next release
      #10 hold = 1;
      repeat (4) @(negedge clk);
      offer(0, 1, 0, 16'h0010);
      check({sa, sr}, 2'h1);
      #10 hold = 0;
      wait_lv(ini, 1, 10);
      @(posedge clk);
      #1 check(sta, 0);
      print_verdict();
   end
endmodule // testbench
